/* serial_vid_packet_decoder.sv */
// Receiver and decoder of three-byte voltage-ID command packets.
`timescale 1ns/1ps
`include "vid_decoder_defines.svh"
module serial_vid_packet_decoder
	import vid_decoder_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_vid_serial_clock,
	input wire logic i_vid_serial_data,
	output logic o_vid_serial_data,
	output logic o_vid_serial_data_oe,
	output vid_cmd_t o_core_cmd,
	output logic o_core_off,
	output logic [20:0] o_core_target_uv,
	output logic o_core_low_power,
	output logic o_core_deep_power,
	output logic signed [4:0] o_core_ll_pct_step,
	output logic o_core_ll_disable,
	output logic signed [5:0] o_core_ofs_mv,
	output logic o_core_ofs_disable,
	output vid_cmd_t o_sec_cmd,
	output logic o_sec_off,
	output logic [20:0] o_sec_target_uv,
	output logic o_sec_low_power,
	output logic o_sec_deep_power,
	output logic signed [4:0] o_sec_ll_pct_step,
	output logic o_sec_ll_disable,
	output logic signed [5:0] o_sec_ofs_mv,
	output logic o_sec_ofs_disable,
	output logic o_cmd_applied,
	output logic o_header_error
);

	// Target in microvolts; a plain linear map covers both halves of the code range.
	function automatic logic [20:0] code_to_uv(input logic [7:0] code);
		logic [20:0] prod;
		prod = 21'(code) * 21'(`VSTEP_UV);
		code_to_uv = 21'(`VTOP_UV) - prod;
	endfunction

	// Slope trim as signed count of 20 percent steps relative to 011.
	function automatic logic signed [4:0] ll_step(input logic [2:0] t);
		ll_step = 5'(signed'({2'b00, t})) - 5'sd3;
	endfunction

	// Offset trim in millivolts; 00 and 10 both give zero change.
	function automatic logic signed [5:0] ofs_mv(input logic [1:0] t);
		logic signed [5:0] r;
		r = 6'sd0;
		unique case (t)
			2'b01: r = -6'sd25;
			2'b11: r = 6'sd25;
			default: r = 6'sd0;
		endcase
		ofs_mv = r;
	endfunction

	// The block never drives the data line, so ack slots stay released.
	assign o_vid_serial_data = 1'b0;
	assign o_vid_serial_data_oe = 1'b0;

	// ---------------- Link domain, clocked by the serial clock and the data line.
	// Start and stop are data edges while clock is high; they are seen by
	// sampling data on both serial clock edges is impossible, so the data
	// line itself clocks detectors, which is the usual two-wire practice.
	logic start_tog;
	logic stop_tog;
	logic frame_clr_seen;
	logic [4:0] bit_cnt;
	logic [26:0] shreg;
	logic [26:0] pkt;
	logic pkt_tog;
	logic link_rst_n;

	assign link_rst_n = i_resetn;

	// Start: data falls while clock high.
	always_ff @(negedge i_vid_serial_data or negedge link_rst_n)
	begin
		if (!link_rst_n)
			start_tog <= 1'b0;
		else if (i_vid_serial_clock)
			start_tog <= ~start_tog;
	end

	// Stop: data rises while clock high.
	always_ff @(posedge i_vid_serial_data or negedge link_rst_n)
	begin
		if (!link_rst_n)
			stop_tog <= 1'b0;
		else if (i_vid_serial_clock)
			stop_tog <= ~stop_tog;
	end

	// A start seen since the last clock edge restarts the bit count.
	always_ff @(posedge i_vid_serial_clock or negedge link_rst_n)
	begin
		if (!link_rst_n)
			frame_clr_seen <= 1'b0;
		else
			frame_clr_seen <= start_tog;
	end

	// Shift bits MSB first; bit positions count from 1 after start.
	always_ff @(posedge i_vid_serial_clock or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			bit_cnt <= 5'h00;
			shreg <= 27'h0;
			pkt <= 27'h0;
			pkt_tog <= 1'b0;
		end
		else
		begin
			if (frame_clr_seen != start_tog)
			begin
				bit_cnt <= 5'h01;
				shreg <= {26'h0, i_vid_serial_data};
			end
			else if (bit_cnt != 5'h00 && bit_cnt < 5'(`PKT_BITS))
			begin
				bit_cnt <= bit_cnt + 5'h01;
				shreg <= {shreg[25:0], i_vid_serial_data};
				if (bit_cnt == 5'(`PKT_BITS - 1))
				begin
					pkt <= {shreg[25:0], i_vid_serial_data};
					pkt_tog <= ~pkt_tog;
				end
			end
			else
				bit_cnt <= 5'h00;
		end
	end

	// ---------------- Core domain.
	// Toggles cross through two flops; packet word is stable long before stop.
	logic [2:0] pkt_sync;
	logic [2:0] stop_sync;
	logic [26:0] pending;
	logic pend_valid;

	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			pkt_sync <= 3'h0;
			stop_sync <= 3'h0;
		end
		else
		begin
			pkt_sync <= {pkt_sync[1:0], pkt_tog};
			stop_sync <= {stop_sync[1:0], stop_tog};
		end
	end

	// Bit n of the packet sits at shift index 27-n.
	function automatic logic pbit(input logic [26:0] p, input int n);
		pbit = p[27 - n];
	endfunction

	logic hdr_ok;
	logic core_sel;
	logic sec_sel;
	vid_cmd_t next_cmd;

	always_comb
	begin
		hdr_ok = ({pbit(pending, 1), pbit(pending, 2), pbit(pending, 3), pbit(pending, 4),
			pbit(pending, 5)} == 5'(`HDR_PATTERN)) && !pbit(pending, `HDR_ZERO_POS);
		core_sel = pbit(pending, `CORE_SEL_POS);
		sec_sel = pbit(pending, `SEC_SEL_POS);
		next_cmd.voltage_code = {pending[27 - `VCODE_HI_FIRST -: 7],
			pbit(pending, `VCODE_LO_POS)};
		next_cmd.power_state_level0_n = pbit(pending, `PSI0_POS);
		next_cmd.power_state_level1_n = pbit(pending, `PSI1_POS);
		next_cmd.telemetry_function_ctrl = pbit(pending, `TFN_POS);
		next_cmd.ll_trim = pending[27 - `LL_FIRST -: 3];
		next_cmd.ofs_trim = pending[27 - `OFS_FIRST -: 2];
	end

	// Hold the packet pending; a later packet before stop replaces it.
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			pending <= 27'h0;
			pend_valid <= 1'b0;
		end
		else if (pkt_sync[2] != pkt_sync[1])
		begin
			pending <= pkt;
			pend_valid <= 1'b1;
		end
		else if (stop_sync[2] != stop_sync[1])
			pend_valid <= 1'b0;
	end

	logic apply;
	assign apply = (stop_sync[2] != stop_sync[1]) && pend_valid;

	localparam vid_cmd_t RST_CMD = '{`RST_VCODE, 1'b1, 1'b1, 1'b0, `RST_LL, `RST_OFS};

	// Commit decoded fields to the selected outputs at stop.
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_core_cmd <= RST_CMD;
			o_sec_cmd <= RST_CMD;
			o_cmd_applied <= 1'b0;
			o_header_error <= 1'b0;
		end
		else
		begin
			o_cmd_applied <= apply && hdr_ok;
			o_header_error <= apply && !hdr_ok;
			if (apply && hdr_ok && core_sel)
				o_core_cmd <= next_cmd;
			if (apply && hdr_ok && sec_sel)
				o_sec_cmd <= next_cmd;
		end
	end

	// Decoded views of the stored commands.
	always_comb
	begin
		o_core_off = o_core_cmd.voltage_code >= `OFF_CODE_MIN;
		o_core_target_uv = o_core_off ? 21'h0 : code_to_uv(o_core_cmd.voltage_code);
		o_core_low_power = !o_core_cmd.power_state_level0_n;
		o_core_deep_power = !o_core_cmd.power_state_level0_n
			&& !o_core_cmd.power_state_level1_n;
		o_core_ll_disable = o_core_cmd.ll_trim == 3'h0;
		o_core_ll_pct_step = ll_step(o_core_cmd.ll_trim);
		o_core_ofs_disable = o_core_cmd.ofs_trim == 2'h0;
		o_core_ofs_mv = ofs_mv(o_core_cmd.ofs_trim);
		o_sec_off = o_sec_cmd.voltage_code >= `OFF_CODE_MIN;
		o_sec_target_uv = o_sec_off ? 21'h0 : code_to_uv(o_sec_cmd.voltage_code);
		o_sec_low_power = !o_sec_cmd.power_state_level0_n;
		o_sec_deep_power = !o_sec_cmd.power_state_level0_n
			&& !o_sec_cmd.power_state_level1_n;
		o_sec_ll_disable = o_sec_cmd.ll_trim == 3'h0;
		o_sec_ll_pct_step = ll_step(o_sec_cmd.ll_trim);
		o_sec_ofs_disable = o_sec_cmd.ofs_trim == 2'h0;
		o_sec_ofs_mv = ofs_mv(o_sec_cmd.ofs_trim);
	end

endmodule // serial_vid_packet_decoder

/* vid_decoder_defines.svh */
// Constants for the serial voltage-ID packet decoder.
`ifndef VID_DECODER_DEFINES_SVH
`define VID_DECODER_DEFINES_SVH
`define PKT_BITS 27
`define HDR_PATTERN 5'h18
`define HDR_ZERO_POS 8
`define CORE_SEL_POS 6
`define SEC_SEL_POS 7
`define PSI0_POS 10
`define VCODE_HI_FIRST 11
`define PSI1_POS 20
`define VCODE_LO_POS 19
`define TFN_POS 21
`define LL_FIRST 22
`define OFS_FIRST 25
`define ACK_POS0 9
`define ACK_POS1 18
`define ACK_POS2 27
`define OFF_CODE_MIN 8'hF8
`define RST_VCODE 8'h00
`define RST_LL 3'h3
`define RST_OFS 2'h2
`define VSTEP_UV 6250
`define VTOP_UV 1550000
`endif

/* vid_decoder_pkg.sv */
// Types shared by the serial voltage-ID packet decoder.
package vid_decoder_pkg;
	typedef struct packed {
		logic [7:0] voltage_code;
		logic power_state_level0_n;
		logic power_state_level1_n;
		logic telemetry_function_ctrl;
		logic [2:0] ll_trim;
		logic [1:0] ofs_trim;
	} vid_cmd_t;

	typedef enum logic [1:0] {
		LINK_IDLE = 2'b00,
		LINK_RECV = 2'b01
	} link_state_t;
endpackage

/* serial_vid_packet_decoder_checker.sv */
// Port-level checker for the serial voltage-ID packet decoder.
`timescale 1ns/1ps
module serial_vid_packet_decoder_checker
	import vid_decoder_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic o_vid_serial_data,
	input wire logic o_vid_serial_data_oe,
	input wire vid_cmd_t o_core_cmd,
	input wire vid_cmd_t o_sec_cmd,
	input wire logic o_core_off,
	input wire logic [20:0] o_core_target_uv,
	input wire logic o_core_low_power,
	input wire logic o_core_deep_power,
	input wire logic signed [4:0] o_core_ll_pct_step,
	input wire logic o_core_ll_disable,
	input wire logic signed [5:0] o_core_ofs_mv,
	input wire logic o_core_ofs_disable,
	input wire logic o_cmd_applied,
	input wire logic o_header_error
);
	// Every check runs on the core clock, and a reset drops any check in flight.
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	a_line_released: assert property (!o_vid_serial_data_oe && !o_vid_serial_data)
		else $error("data line driven");
	a_core_at_stop: assert property ($changed(o_core_cmd) |-> o_cmd_applied)
		else $error("core command changed without commit");
	a_sec_at_stop: assert property ($changed(o_sec_cmd) |-> o_cmd_applied)
		else $error("secondary command changed without commit");
	a_pulse_single: assert property (o_cmd_applied |=> !o_cmd_applied && !o_header_error)
		else $error("commit pulse too long");
	a_off_codes: assert property (o_core_off == (o_core_cmd.voltage_code >= 8'hF8))
		else $error("off decode wrong");
	a_target_step: assert property (!o_core_off |->
		o_core_target_uv == 21'(1550000 - 6250 * o_core_cmd.voltage_code))
		else $error("target wrong");
	a_psi_levels: assert property (o_core_low_power == !o_core_cmd.power_state_level0_n &&
		o_core_deep_power == !(o_core_cmd.power_state_level0_n | o_core_cmd.power_state_level1_n))
		else $error("power state decode wrong");
	a_slope_trim: assert property (o_core_ll_disable == (o_core_cmd.ll_trim == 3'h0) &&
		o_core_ll_pct_step == $signed({2'h0, o_core_cmd.ll_trim}) - 5'sh3)
		else $error("slope decode wrong");
	a_offset_trim: assert property (o_core_ofs_disable == (o_core_cmd.ofs_trim == 2'h0) &&
		o_core_ofs_mv == (o_core_cmd.ofs_trim == 2'h1 ? -6'sh19 :
		o_core_cmd.ofs_trim == 2'h3 ? 6'sh19 : 6'sh0))
		else $error("offset decode wrong");
	c_applied: cover property (o_cmd_applied);
	c_header_bad: cover property (o_header_error);
	c_core_off: cover property (o_core_off);
endmodule // serial_vid_packet_decoder_checker

bind serial_vid_packet_decoder serial_vid_packet_decoder_checker i_chk (.i_core_clk, .i_resetn,
	.o_vid_serial_data, .o_vid_serial_data_oe, .o_core_cmd, .o_sec_cmd, .o_core_off,
	.o_core_target_uv, .o_core_low_power, .o_core_deep_power, .o_core_ll_pct_step,
	.o_core_ll_disable, .o_core_ofs_mv, .o_core_ofs_disable, .o_cmd_applied, .o_header_error);

/* serial_vid_host_model.sv */
// Behavioural host that masters the serial voltage-ID lines.
`timescale 1ns/1ps
module serial_vid_host_model
(
	output logic o_clk,
	output logic o_data
);
	// Idle bus: clock parked high, data at its pull-up level.
	initial
	begin
		o_clk = 1'b1;
		o_data = 1'b1;
	end
	// Start, then n bits MSB first at a 6 ns period; the clock then stands low.
	task automatic send(input logic [26:0] p, input int n);
		#7 o_data = 1'b0;
		#3 o_clk = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			o_data = p[26 - i];
			#3 o_clk = 1'b1;
			#3 o_clk = 1'b0;
		end
		o_data = 1'b0;
	endtask
	// Stop well after the last bit so the core domain has seen the packet.
	task automatic stop();
		#200 o_clk = 1'b1;
		#3 o_data = 1'b1;
	endtask
endmodule // serial_vid_host_model

/* serial_vid_packet_decoder_bench.sv */
// Self-checking bench for the serial voltage-ID packet decoder.
`timescale 1ns/1ps
module serial_vid_packet_decoder_bench
	import vid_decoder_pkg::*;
;
	logic i_core_clk = 1'b0;
	logic i_resetn = 1'b0;
	wire scl, sda, applied, hdr_err, core_off, sec_off;
	vid_cmd_t core_cmd, sec_cmd, c, ecore, esec;
	wire [20:0] core_tgt, sec_tgt;
	wire sec_lp, sec_dp, sec_lld, sec_ofsd;
	wire [4:0] sec_lls;
	wire [5:0] sec_ofs;
	int mismatches = 0, n_checks = 0, seed = 41278, n, k;
	logic [31:0] r;
	logic [7:0] corner [5] = '{8'h00, 8'h80, 8'hF7, 8'hF8, 8'hFF};
	logic [1:0] sel, got;
	logic bad;
	always #20 i_core_clk = ~i_core_clk;
	serial_vid_host_model i_serial_vid_host_model (.o_clk(scl), .o_data(sda));
	serial_vid_packet_decoder i_serial_vid_packet_decoder (.i_core_clk, .i_resetn,
		.i_vid_serial_clock(scl), .i_vid_serial_data(sda), .o_vid_serial_data(),
		.o_vid_serial_data_oe(), .o_core_cmd(core_cmd), .o_core_off(core_off),
		.o_core_target_uv(core_tgt), .o_core_low_power(), .o_core_deep_power(),
		.o_core_ll_pct_step(), .o_core_ll_disable(), .o_core_ofs_mv(), .o_core_ofs_disable(),
		.o_sec_cmd(sec_cmd), .o_sec_off(sec_off), .o_sec_target_uv(sec_tgt),
		.o_sec_low_power(sec_lp), .o_sec_deep_power(sec_dp), .o_sec_ll_pct_step(sec_lls),
		.o_sec_ll_disable(sec_lld), .o_sec_ofs_mv(sec_ofs), .o_sec_ofs_disable(sec_ofsd),
		.o_cmd_applied(applied), .o_header_error(hdr_err));
	// Off codes read as a zero target in this design.
	function automatic int tgt(input logic [7:0] v);
		return v >= 8'hF8 ? 0 : 1550000 - 6250 * v;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// A hung handshake would otherwise stall the run forever.
	initial
	begin
		#400000;
		mismatches++;
		results();
	end
	// Two passes, the second through a reset in mid-run, each a burst of packets.
	initial
	begin
		for (int pass = 0; pass < 2; pass++)
		begin
			@(posedge i_core_clk) i_resetn <= 1'b0;
			repeat (6) @(posedge i_core_clk);
			i_resetn <= 1'b1;
			repeat (4) @(posedge i_core_clk);
			ecore = {8'h00, 1'b1, 1'b1, 1'b0, 3'h3, 2'h2};
			esec = ecore;
			check(core_cmd, ecore);
			check(core_tgt, 1550000);
			for (int i = 0; i < 30; i++)
			begin
				r = $random(seed);
				c = r[15:0];
				c.voltage_code = i < 5 ? corner[i] : c.voltage_code;
				c.ll_trim = i[2:0];
				c.ofs_trim = i[1:0];
				sel = i < 5 ? 2'b11 : r[17:16];
				bad = r[20:18] == 3'h0;
				n = i == 20 ? 20 : 27;
				// Ack slots carry the released level and no command data.
				// Bit 6 is the core selector and carries sel[1]; bit 7 carries sel[0].
				i_serial_vid_host_model.send({bad ? 5'b11001 : 5'b11000, sel, 1'b0, 1'b1,
					c.power_state_level0_n, c.voltage_code[7:1], 1'b1, c.voltage_code[0],
					c.power_state_level1_n, c.telemetry_function_ctrl, c.ll_trim, c.ofs_trim,
					1'b1}, n);
				repeat (4) @(negedge i_core_clk);
				check({core_cmd, sec_cmd}, {ecore, esec});
				i_serial_vid_host_model.stop();
				got = 2'b00;
				for (k = 0; k < 10 && got == 2'b00; k++)
				begin
					@(negedge i_core_clk);
					got = {applied, hdr_err};
				end
				check(got, n < 27 ? 2'b00 : bad ? 2'b01 : 2'b10);
				if (n == 27 && !bad && sel[1])
					ecore = c;
				if (n == 27 && !bad && sel[0])
					esec = c;
				check({core_cmd, sec_cmd}, {ecore, esec});
				check(core_tgt, tgt(ecore.voltage_code));
				check({sec_off, sec_tgt}, {esec.voltage_code >= 8'hF8, 21'(tgt(esec.voltage_code))});
				check({sec_lp, sec_dp}, {!esec.power_state_level0_n,
					!esec.power_state_level0_n && !esec.power_state_level1_n});
				check({sec_lld, sec_lls}, {esec.ll_trim == 3'h0,
					5'({2'b00, esec.ll_trim}) - 5'h03});
				check({sec_ofsd, sec_ofs}, {esec.ofs_trim == 2'h0, esec.ofs_trim == 2'h1 ? 6'h27 :
					esec.ofs_trim == 2'h3 ? 6'h19 : 6'h00});
			end
		end
		results();
	end
endmodule // serial_vid_packet_decoder_bench
